// File: inc/bit_irq_pkg.sv
// Purpose: shared constants, types and carriers of the terminal interrupt
//          and built-in-test status block
// Assumes: 16-bit registers reached by register index over a plain port
// Notes:   the version byte value is arbitrary
package bit_irq_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;

  // register indexes (plain port, the index is the address)
  localparam logic [ADDR_W-1:0] REG_MASK = 6'h03;
  localparam logic [ADDR_W-1:0] REG_PEND = 6'h04;
  localparam logic [ADDR_W-1:0] REG_LOGP = 6'h05;
  localparam logic [ADDR_W-1:0] REG_BIT  = 6'h06;

  // pending / mask bit positions
  localparam int MEMORY_ACCESS_FAIL_BIT   = 15;
  localparam int LOOPBACK_FAIL_BIT        = 14;
  localparam int ADDRESS_PARITY_FAIL_BIT  = 13;
  localparam int MESSAGE_ERROR_BIT        = 11;
  localparam int SUBADDRESS_TOUCHED_BIT   = 10;
  localparam int BROADCAST_RECEIVED_BIT   = 9;
  localparam int INDEX_ZERO_BIT           = 8;
  localparam int ILLEGAL_COMMAND_BIT      = 7;
  localparam int END_OF_LIST_BIT          = 5;
  localparam int BC_CHECK_FAIL_BIT        = 4;
  localparam int BAD_OPCODE_BIT           = 3;
  localparam int RETRY_FAIL_BIT           = 2;
  localparam int BLOCK_ACCESSED_BIT       = 1;
  localparam int MONITOR_COUNT_BIT        = 0;

  // built-in-test bit positions beyond the shared top three
  localparam int CHANNEL_A_TIMEOUT_BIT    = 11;
  localparam int CHANNEL_B_TIMEOUT_BIT    = 10;

  // priority grouping of the pending register
  localparam int HIGH_GROUP_MSB           = 15;
  localparam int HIGH_GROUP_LSB           = 12;
  localparam int MEDIUM_GROUP_MSB         = 11;
  localparam int MEDIUM_GROUP_LSB         = 0;

  // implemented bits (12 and 6 of pending are unused, 12 of test unused)
  localparam logic [DATA_W-1:0] PEND_USED_MASK = 16'hefbf;
  localparam logic [DATA_W-1:0] BIT_USED_MASK  = 16'hefff;

  // reset values
  localparam logic [DATA_W-1:0] MASK_RESET     = 16'h0000;
  localparam logic [DATA_W-1:0] PEND_RESET     = 16'h0000;
  localparam logic [DATA_W-1:0] LOGP_RESET     = 16'h0000;
  localparam logic [7:0]        CORE_VERSION   = 8'h01; // arbitrary value
  localparam logic [DATA_W-1:0] BIT_RESET      = {8'h00, CORE_VERSION};

  // log ring: 32 words, low five bits are the device write pointer
  localparam int unsigned LOG_IDX_W = 5;

  // memory access watchdog, a longest time so rounded down
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned MEM_TIMEOUT_NS  = 1000;
  localparam int unsigned MEM_CNT_W       = 8;
  localparam logic [MEM_CNT_W-1:0] MEM_TIMEOUT_CYC =
    MEM_CNT_W'(MEM_TIMEOUT_NS / CLK_PERIOD_NS);

  // operating mode as selected by the mode pins
  typedef enum logic [1:0] {
    MODE_BC   = 2'h0,
    MODE_RT   = 2'h1,
    MODE_BM   = 2'h2,
    MODE_BMRT = 2'h3
  } mode_e;

  // watchdog states
  typedef enum logic [1:0] {
    TMR_IDLE = 2'b01,
    TMR_RUN  = 2'b10
  } tmr_state_e;

  // word-level receive errors, each a one-cycle pulse
  typedef struct packed {
    logic manchester;
    logic sync_field;
    logic word_count_high;
    logic word_count_low;
    logic word_parity;
    logic bit_count_high;
    logic bit_count_low;
    logic protocol;
  } msg_err_s;

  // terminal-mode events, each a one-cycle pulse except the select level
  typedef struct packed {
    logic message_done;
    logic subaddress_irq_select;
    logic status_message_error_flag_sent;
    logic broadcast_valid;
    logic index_to_zero;
    logic circular_wrap;
    logic illegal_command;
  } rt_evt_s;

  // controller-mode events, each a one-cycle pulse
  typedef struct packed {
    logic end_of_list;
    logic rtrt_address_match;
    logic rtrt_tr_bad;
    logic broadcast_transmit;
    logic reserved_opcode;
    logic retries_failed;
    logic block_access_op;
  } bc_evt_s;

  // loopback word pair
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] encoder_word;
    logic [DATA_W-1:0] decoder_word;
  } loop_s;

endpackage : bit_irq_pkg

// File: verilog/mem_access_timer.sv
// Purpose: down-counting watchdog started by each memory access
// Assumes: start and done are one-cycle pulses in the mclk domain
// Notes:   a new start while running restarts the count
`timescale 1ns/1ps
module mem_access_timer
  import bit_irq_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // access handshake
  input  wire logic mem_start,
  input  wire logic mem_done,
  // one-cycle pulse when the count ran out first
  output logic      expired
);

  tmr_state_e             state_r;
  tmr_state_e             state_nxt;
  logic [MEM_CNT_W-1:0]   cnt_r;
  logic [MEM_CNT_W-1:0]   cnt_nxt;
  logic                   expired_nxt;
  logic                   last_tick;

  assign last_tick = (cnt_r == MEM_CNT_W'(1));

  // next state: done beats the last tick, so a late finish is not a fail
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    expired_nxt = 1'b0;
    unique case (state_r)
      TMR_IDLE: begin
        if (mem_start) begin
          state_nxt = TMR_RUN;
          cnt_nxt   = MEM_TIMEOUT_CYC;
        end
      end
      TMR_RUN: begin
        if (mem_start) begin
          cnt_nxt = MEM_TIMEOUT_CYC;
        end else if (mem_done) begin
          state_nxt = TMR_IDLE;
        end else if (last_tick) begin
          state_nxt   = TMR_IDLE;
          cnt_nxt     = '0;
          expired_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - MEM_CNT_W'(1);
        end
      end
      default: begin
        state_nxt = TMR_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= TMR_IDLE;
      cnt_r   <= '0;
      expired <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      expired <= expired_nxt;
    end
  end

endmodule : mem_access_timer

// File: verilog/bit_irq_status.sv
// Purpose: interrupt mask, pending flags, log pointer and built-in-test
//          status of a serial bus terminal core
// Assumes: event inputs are one-cycle pulses synchronous to mclk
// Notes:   registers are addressed by index, read data follow one cycle
//
// What this block does
// - masked event never reaches pending flags or interrupt outputs
// - unmasking later raises nothing for an event already gone
// - any access to another register clears all pending flags
// - high interrupt output follows pending bits 15 to 12
// - medium interrupt output follows pending bits 11 to 0
// - memory access watchdog expiry sets memory fail flag, any mode
// - memory fail abandons command; terminal mode also releases bus
// - controller and terminal compare looped words; mismatch sets bit 14
// - terminal address parity error sets bit 13, inhibits run and buses
// - any word or protocol error sets message error bit 11
// - terminal status message error sent also sets bit 11
// - terminal message on selected subaddress sets bit 10
// - terminal valid broadcast sets bit 9 and suppresses status word
// - terminal index reaching zero or buffer wrap sets bit 8
// - terminal illegal command sets bit 7, replies status only
// - controller end of list command sets bit 5
// - controller address, direction or broadcast fault sets bit 4, halts
// - controller reserved opcode sets bit 3 and halts
// - controller retries exhausted sets bit 2; block access sets bit 1
// - monitor block counter at zero sets bit 0, errors included
// - log pointer: software base in top 11 bits, device advances low 5
// - test register writable except bit 12; low byte holds version after reset
// - transmitter timeout sets test bit 11 for A, 10 for B
// - control register self-test request is unsupported, starts nothing
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module bit_irq_status
  import bit_irq_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              resetn,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  // operating mode and terminal address straps
  input  wire mode_e             mode,
  input  wire logic [4:0]        rt_address,
  input  wire logic              rt_address_parity,
  // memory access handshake
  input  wire logic              mem_start,
  input  wire logic              mem_done,
  // event sources
  input  wire loop_s             loopback,
  input  wire msg_err_s          msg_errors,
  input  wire rt_evt_s           rt_events,
  input  wire bc_evt_s           bc_events,
  input  wire logic              monitor_count_zero,
  input  wire logic              channel_a_tx_timeout,
  input  wire logic              channel_b_tx_timeout,
  input  wire logic              log_entry_written,
  // interrupt outputs
  output logic                   irq_high_out,
  output logic                   irq_medium_out,
  // control back to the message engine
  output logic                   abort_command,
  output logic                   release_bus,
  output logic                   execution_halt,
  output logic                   execution_enable_block,
  output logic                   bus_a_enable,
  output logic                   bus_b_enable,
  output logic                   status_suppress,
  output logic                   status_only_reply,
  output logic                   status_message_error,
  // memory-side views
  output logic      [DATA_W-1:0] log_address_word,
  output logic      [DATA_W-1:0] self_test_word
);

  // register state
  logic [DATA_W-1:0] interrupt_mask_bits_r;
  logic [DATA_W-1:0] interrupt_mask_bits_nxt;
  logic [DATA_W-1:0] pending_interrupt_flags_r;
  logic [DATA_W-1:0] pending_interrupt_flags_nxt;
  logic [DATA_W-1:0] interrupt_log_pointer_r;
  logic [DATA_W-1:0] interrupt_log_pointer_nxt;
  logic [DATA_W-1:0] built_in_test_status_r;
  logic [DATA_W-1:0] built_in_test_status_nxt;
  logic              parity_bad_r;

  // decode and event wires
  logic              hit_mask;
  logic              hit_pend;
  logic              hit_logp;
  logic              hit_bit;
  logic              other_access;
  logic              is_bc;
  logic              is_rt;
  logic              is_bm;
  logic              memory_access_fail;
  logic              loopback_compare_fail;
  logic              parity_bad;
  logic              address_parity_fail;
  logic              message_error_flag;
  logic              subaddress_touched;
  logic              broadcast_received;
  logic              index_reached_zero;
  logic              illegal_command_flag;
  logic              end_of_list_flag;
  logic              bc_check_fail;
  logic              bad_opcode_flag;
  logic              retry_fail_flag;
  logic              block_accessed_flag;
  logic              monitor_count_flag;
  logic [DATA_W-1:0] event_vec;
  logic [DATA_W-1:0] pend_set;
  logic [DATA_W-1:0] pend_kept;
  logic [DATA_W-1:0] bit_set;
  logic [DATA_W-1:0] bit_base;
  logic [DATA_W-1:0] log_advanced;
  logic [DATA_W-1:0] rd_mux;

  // register index match, used by both the write and read paths
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] idx);
    reg_hit = (a == idx);
  endfunction : reg_hit

  // address decode
  assign hit_mask = reg_hit(addr, REG_MASK);
  assign hit_pend = reg_hit(addr, REG_PEND);
  assign hit_logp = reg_hit(addr, REG_LOGP);
  assign hit_bit  = reg_hit(addr, REG_BIT);

  // clear on access
  // any other core index counts, including ones outside this block
  assign other_access = (rd_en | wr_en) & ~hit_pend;

  // mode qualifiers; combined monitor-terminal counts as both
  assign is_bc = (mode == MODE_BC);
  assign is_rt = (mode == MODE_RT) | (mode == MODE_BMRT);
  assign is_bm = (mode == MODE_BM) | (mode == MODE_BMRT);

  mem_access_timer u_mem_timer (
    .mclk      (mclk),
    .resetn    (resetn),
    .mem_start (mem_start),
    .mem_done  (mem_done),
    .expired   (memory_access_fail)
  );

  assign loopback_compare_fail = (is_bc | is_rt) & loopback.valid &
    (loopback.encoder_word != loopback.decoder_word);

  // odd address parity
  // the flag fires once on the rising edge of the error so that a pending
  // clear by software is not instantly undone by a standing strap fault
  assign parity_bad          = is_rt &
                               ~(^{rt_address, rt_address_parity});
  assign address_parity_fail = parity_bad & ~parity_bad_r;

  assign message_error_flag = (|msg_errors) |
    (is_rt & (rt_events.status_message_error_flag_sent | rt_events.illegal_command));

  assign subaddress_touched   = is_rt & rt_events.message_done &
                                rt_events.subaddress_irq_select;
  assign broadcast_received   = is_rt & rt_events.broadcast_valid;
  assign index_reached_zero   = is_rt & (rt_events.index_to_zero |
                                         rt_events.circular_wrap);
  assign illegal_command_flag = is_rt & rt_events.illegal_command;

  assign end_of_list_flag    = is_bc & bc_events.end_of_list;
  assign bc_check_fail       = is_bc & (bc_events.rtrt_address_match |
                                        bc_events.rtrt_tr_bad |
                                        bc_events.broadcast_transmit);
  assign bad_opcode_flag     = is_bc & bc_events.reserved_opcode;
  assign retry_fail_flag     = is_bc & bc_events.retries_failed;
  assign block_accessed_flag = is_bc & bc_events.block_access_op;
  // monitor counter
  // the engine counts every message, erroneous or not
  assign monitor_count_flag  = is_bm & monitor_count_zero;

  // event vector in pending-register bit order
  always_comb begin
    event_vec                          = '0;
    event_vec[MEMORY_ACCESS_FAIL_BIT]  = memory_access_fail;
    event_vec[LOOPBACK_FAIL_BIT]       = loopback_compare_fail;
    event_vec[ADDRESS_PARITY_FAIL_BIT] = address_parity_fail;
    event_vec[MESSAGE_ERROR_BIT]       = message_error_flag;
    event_vec[SUBADDRESS_TOUCHED_BIT]  = subaddress_touched;
    event_vec[BROADCAST_RECEIVED_BIT]  = broadcast_received;
    event_vec[INDEX_ZERO_BIT]          = index_reached_zero;
    event_vec[ILLEGAL_COMMAND_BIT]     = illegal_command_flag;
    event_vec[END_OF_LIST_BIT]         = end_of_list_flag;
    event_vec[BC_CHECK_FAIL_BIT]       = bc_check_fail;
    event_vec[BAD_OPCODE_BIT]          = bad_opcode_flag;
    event_vec[RETRY_FAIL_BIT]          = retry_fail_flag;
    event_vec[BLOCK_ACCESSED_BIT]      = block_accessed_flag;
    event_vec[MONITOR_COUNT_BIT]       = monitor_count_flag;
  end

  // no memory of masked
  // masked events are dropped outright, never parked for a later unmask
  assign pend_set = event_vec & interrupt_mask_bits_r & PEND_USED_MASK;

  // clear then set
  // a new event in the clearing cycle survives: set wins over clear
  assign pend_kept = other_access ? PEND_RESET : pending_interrupt_flags_r;
  assign pending_interrupt_flags_nxt = pend_kept | pend_set;

  // mask register write
  assign interrupt_mask_bits_nxt = (wr_en & hit_mask) ?
                                   wr_data : interrupt_mask_bits_r;

  // log ring pointer
  // software reload wins over an advance in the same cycle; the advance
  // wraps inside the 32-word boundary and never touches the base
  assign log_advanced = {interrupt_log_pointer_r[DATA_W-1:LOG_IDX_W],
                         interrupt_log_pointer_r[LOG_IDX_W-1:0] +
                         LOG_IDX_W'(1)};
  assign interrupt_log_pointer_nxt =
    (wr_en & hit_logp) ? wr_data :
    log_entry_written  ? log_advanced : interrupt_log_pointer_r;

  // no self-test start
  // a write only stores bits; nothing here launches a test sequence
  assign bit_base = (wr_en & hit_bit) ? (wr_data & BIT_USED_MASK) :
                                        built_in_test_status_r;

  // hardware-set test bits: shared top three and channel timeouts
  // hardware sets here win over a same-cycle software write
  always_comb begin
    bit_set                          = '0;
    bit_set[MEMORY_ACCESS_FAIL_BIT]  = memory_access_fail;
    bit_set[LOOPBACK_FAIL_BIT]       = loopback_compare_fail;
    bit_set[ADDRESS_PARITY_FAIL_BIT] = address_parity_fail;
    bit_set[CHANNEL_A_TIMEOUT_BIT]   = channel_a_tx_timeout;
    bit_set[CHANNEL_B_TIMEOUT_BIT]   = channel_b_tx_timeout;
  end
  assign built_in_test_status_nxt = bit_base | bit_set;

  // read selection; unmapped indexes read as zero
  assign rd_mux = hit_mask ? interrupt_mask_bits_r     :
                  hit_pend ? pending_interrupt_flags_r :
                  hit_logp ? interrupt_log_pointer_r   :
                  hit_bit  ? built_in_test_status_r    : '0;

  // register file
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      interrupt_mask_bits_r     <= MASK_RESET;
      pending_interrupt_flags_r <= PEND_RESET;
      interrupt_log_pointer_r   <= LOGP_RESET;
      built_in_test_status_r    <= BIT_RESET;
      parity_bad_r              <= 1'b0;
    end else begin
      interrupt_mask_bits_r     <= interrupt_mask_bits_nxt;
      pending_interrupt_flags_r <= pending_interrupt_flags_nxt;
      interrupt_log_pointer_r   <= interrupt_log_pointer_nxt;
      built_in_test_status_r    <= built_in_test_status_nxt;
      parity_bad_r              <= parity_bad;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_en ? rd_mux : '0;
    end
  end

  // high and medium group outputs
  // taken from the next-state so the pins move with the flags
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_high_out   <= 1'b0;
      irq_medium_out <= 1'b0;
    end else begin
      irq_high_out   <=
        |pending_interrupt_flags_nxt[HIGH_GROUP_MSB:HIGH_GROUP_LSB];
      irq_medium_out <=
        |pending_interrupt_flags_nxt[MEDIUM_GROUP_MSB:MEDIUM_GROUP_LSB];
    end
  end

  // engine reactions to faults and events
  // these are raw event reactions, not gated by the mask: a masked fault
  // must still stop the engine even though nobody is told about it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      abort_command          <= 1'b0;
      release_bus            <= 1'b0;
      execution_halt         <= 1'b0;
      execution_enable_block <= 1'b0;
      bus_a_enable           <= 1'b0;
      bus_b_enable           <= 1'b0;
      status_suppress        <= 1'b0;
      status_only_reply      <= 1'b0;
      status_message_error   <= 1'b0;
    end else begin
      abort_command          <= memory_access_fail;
      release_bus            <= memory_access_fail & is_rt;
      execution_halt         <= bc_check_fail | bad_opcode_flag;
      execution_enable_block <= parity_bad;
      bus_a_enable           <= ~parity_bad;
      bus_b_enable           <= ~parity_bad;
      status_suppress        <= broadcast_received;
      status_only_reply      <= illegal_command_flag;
      status_message_error   <= illegal_command_flag;
    end
  end

  // views handed to the memory engine and the test word transmitter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      log_address_word <= LOGP_RESET;
      self_test_word   <= BIT_RESET;
    end else begin
      log_address_word <= interrupt_log_pointer_nxt;
      self_test_word   <= built_in_test_status_nxt;
    end
  end

endmodule : bit_irq_status

// File: verification/bit_irq_status_properties.sv
// Purpose: concurrent checks on the status block ports
// Assumes: one mclk domain, resetn active low
// Notes:   watchdog age is counted in helper logic
`timescale 1ns/1ps
module bit_irq_status_properties
  import bit_irq_pkg::*;
(
  // clock, reset and register port
  input wire logic              mclk,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire mode_e             mode,
  // watched events and outputs
  input wire logic              mem_start,
  input wire logic              abort_command,
  input wire logic              release_bus,
  input wire logic              execution_halt,
  input wire logic              status_only_reply,
  input wire logic              status_message_error,
  input wire logic              irq_high_out,
  input wire logic              irq_medium_out,
  input wire logic [DATA_W-1:0] log_address_word
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [7:0] age_r;
  wire        other_acc = (wr_en | rd_en) && (addr != REG_PEND);
  // age of the latest access; stops at wrap, long after any expiry
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) age_r <= 8'h00;
    else if (mem_start) age_r <= 8'h01;
    else if (age_r != 8'h00) age_r <= age_r + 8'h01;
  end
  a_abort_timing: assert property (
    abort_command |-> age_r == MEM_TIMEOUT_CYC + 8'h02)
    else $error("abort not at watchdog expiry");
  a_release_rt: assert property (
    release_bus |-> abort_command && mode[0])
    else $error("bus released outside terminal expiry");
  a_status_only: assert property (
    status_only_reply |-> status_message_error)
    else $error("status only reply without error bit");
  a_high_fall: assert property (
    $fell(irq_high_out) |-> $past(other_acc) || $past(other_acc, 2))
    else $error("high irq dropped without clearing access");
  a_medium_fall: assert property (
    $fell(irq_medium_out) |-> $past(other_acc) || $past(other_acc, 2))
    else $error("medium irq dropped without clearing access");
  a_pend_keeps: assert property (
    rd_en && addr == REG_PEND && irq_medium_out |=> irq_medium_out)
    else $error("pending read cleared the flags");
  a_log_base: assert property (
    !$past(wr_en) && !$past(wr_en, 2) |-> $stable(log_address_word[15:5]))
    else $error("log base moved without a write");
  a_halt_mode: assert property (
    execution_halt |-> $past(mode) == MODE_BC)
    else $error("halt outside controller mode");
endmodule : bit_irq_status_properties
bind bit_irq_status bit_irq_status_properties chk (.*);

// File: verification/bit_irq_status_tb_top.sv
// Purpose: self-checking bench of the interrupt and test status block
// Assumes: one-cycle read latency, events as one-cycle pulses
// Notes:   the watchdog expiry is waited out in full
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module bit_irq_status_tb_top;
  import bit_irq_pkg::*;
  // stimulus
  logic              mclk, resetn, wr_en, rd_en, rt_address_parity;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data, mk, log_address_word, self_test_word;
  logic [4:0]        rt_address;
  logic [27:0]       ev_v;
  mode_e             mode;
  loop_s             loopback;
  msg_err_s          msg_errors;
  rt_evt_s           rt_events;
  bc_evt_s           bc_events;
  logic              monitor_count_zero, channel_a_tx_timeout, mem_start;
  logic              channel_b_tx_timeout, log_entry_written, mem_done;
  // observed outputs
  logic irq_high_out, irq_medium_out, abort_command, release_bus;
  logic execution_halt, execution_enable_block, bus_a_enable, bus_b_enable;
  logic status_suppress, status_only_reply, status_message_error;
  int   checks, error_cnt, cyc;
  int   bcb[7] = '{1, 2, 3, 4, 4, 4, 5};
  // one vector carries every event pulse except the loopback pair
  assign {msg_errors, rt_events, bc_events, monitor_count_zero,
          channel_a_tx_timeout, channel_b_tx_timeout, log_entry_written,
          mem_start, mem_done} = ev_v;
  bit_irq_status uut (.*);
  task automatic complete_run();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge mclk);
    wr_en   <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 `CHK("rd_data", e, rd_data)
  endtask : rd
  task automatic pul(input mode_e m, input logic [27:0] v);
    @(posedge mclk);
    mode <= m;
    ev_v <= v;
    @(posedge mclk);
    ev_v <= '0;
    #1;
  endtask : pul
  // clear by a mask read, fire, then look at irqs and pending flags
  task automatic ev(input mode_e m, input logic [27:0] v,
                    input logic [15:0] e);
    rd(REG_MASK, mk);
    pul(m, v);
    `CHK("irq_high_out", |e[15:12], irq_high_out)
    `CHK("irq_medium_out", |e[11:0], irq_medium_out)
    `CHK("status_suppress", e[9], status_suppress)
    `CHK("execution_halt", |e[4:3], execution_halt)
    `CHK("status_only_reply", e[7], status_only_reply)
    `CHK("status_message_error", e[7], status_message_error)
    rd(REG_PEND, e);
  endtask : ev
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ceiling well above the under four hundred cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    {resetn, wr_en, rd_en, addr, wr_data, ev_v, rt_address} = '0;
    mode = MODE_BC;
    rt_address_parity = 1'b1;
    loopback = '0;
    mk = 16'h0000;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    rd(REG_PEND, 16'h0000);
    rd(REG_LOGP, 16'h0000);
    rd(REG_BIT, 16'h0001);
    rd(6'h2a, 16'h0000);
    ev(MODE_BC, 28'h1000, 16'h0000);
    mk = 16'hffff;
    wr(REG_MASK, mk);
    #1 `CHK("irq_medium_out", 1'b0, irq_medium_out)
    for (int i = 20; i < 28; i++) ev(MODE_BM, 28'h1 << i, 16'h0800);
    for (int i = 6; i < 13; i++)
      ev(MODE_BC, 28'h1 << i, 16'h1 << bcb[i-6]);
    ev(MODE_RT, 28'h1000, 16'h0000);
    ev(MODE_RT, 28'h20000, 16'h0800);
    ev(MODE_RT, 28'h10000, 16'h0200);
    ev(MODE_RT, 28'h08000, 16'h0100);
    ev(MODE_RT, 28'h04000, 16'h0100);
    ev(MODE_RT, 28'h02000, 16'h0880);
    ev(MODE_RT, 28'hc0000, 16'h0400);
    ev(MODE_RT, 28'h80000, 16'h0000);
    ev(MODE_BM, 28'h00020, 16'h0001);
    // looped word differs from the sent one
    rd(REG_MASK, mk);
    @(posedge mclk);
    mode     <= MODE_RT;
    loopback <= {1'b1, 16'h1234, 16'h1235};
    @(posedge mclk);
    loopback <= '0;
    #1 `CHK("irq_high_out", 1'b1, irq_high_out)
    rd(REG_PEND, 16'h4000);
    // terminal address with even parity
    @(posedge mclk);
    rt_address <= 5'h01;
    repeat (2) @(posedge mclk);
    #1 `CHK("bus_a_enable", 1'b0, bus_a_enable)
    `CHK("execution_enable_block", 1'b1, execution_enable_block)
    rd(REG_PEND, 16'h6000);
    @(posedge mclk);
    rt_address <= 5'h00;
    repeat (2) @(posedge mclk);
    #1 `CHK("bus_b_enable", 1'b1, bus_b_enable)
    // memory access left hanging, then one finished in time
    rd(REG_MASK, mk);
    pul(MODE_RT, 28'h2);
    repeat (41) @(posedge mclk);
    #1 `CHK("abort_command", 1'b1, abort_command)
    `CHK("release_bus", 1'b1, release_bus)
    rd(REG_PEND, 16'h8000);
    rd(REG_BIT, 16'he001);
    pul(MODE_RT, 28'h2);
    pul(MODE_RT, 28'h1);
    repeat (45) @(posedge mclk);
    rd(REG_PEND, 16'h0000);
    wr(REG_BIT, 16'hffff);
    rd(REG_BIT, 16'hefff);
    `CHK("self_test_word", 16'hefff, self_test_word)
    wr(REG_BIT, 16'h0000);
    pul(MODE_BC, 28'h10);
    pul(MODE_BC, 28'h8);
    rd(REG_BIT, 16'h0c00);
    wr(REG_LOGP, 16'h1fe0);
    repeat (33) pul(MODE_BC, 28'h4);
    rd(REG_LOGP, 16'h1fe1);
    `CHK("log_address_word", 16'h1fe1, log_address_word)
    complete_run();
  end
endmodule : bit_irq_status_tb_top
